//--- hw/tpf_pkg.sv
// Shared constants and types for the triple port queue access block
package tpf_pkg;

  // Queue geometry, fixed at the smallest variant
  localparam int DEPTH = 2048;
  localparam int AW = 11;
  localparam int PW = 12;
  localparam int DW = 36;
  localparam int HW = 18;

  // Pointer arithmetic constants at pointer width
  localparam logic [PW-1:0] DEPTH_CNT = 12'h800;
  localparam logic [PW-1:0] PTR_ZERO = 12'h000;
  localparam logic [PW-1:0] WORDS_NONE = 12'h000;

  // Queue indexes: a_to_b_queue and c_to_a_queue
  localparam int Q1 = 0;
  localparam int Q2 = 1;

  // Reset values of flags and drivers, and the zero pad above the half word
  localparam logic FLAG_RST = 1'b0;
  localparam logic OE_N_RST = 1'b1;
  localparam logic [DW-1:0] WORD_RST = 36'h000000000;
  localparam logic [DW-HW-1:0] HALF_PAD = 18'h00000;

  typedef logic [PW-1:0] tpf_ptr_t;
  typedef logic [DW-1:0] tpf_word_t;

  // Per-queue pointers, output register and flags
  typedef struct packed {
    tpf_ptr_t wptr;
    tpf_ptr_t rptr;
    tpf_word_t out;
    logic data_flag;
    logic space_flag;
  } tpf_qstate_t;

  // Whole state of the top module
  typedef struct packed {
    tpf_qstate_t [1:0] q;
    logic almost_empty;
    logic almost_full;
    logic a_oe_n;
    logic b_oe_n;
  } tpf_state_t;

  // Pointer capture pipeline state
  typedef struct packed {
    tpf_ptr_t s1;
    tpf_ptr_t s2;
  } tpf_sync_t;

  // Queue storage
  typedef struct packed {
    logic [DEPTH-1:0][DW-1:0] word;
  } tpf_mem_t;

endpackage

//--- hw/tpf_mem.sv
// Flip-flop storage for one queue, written by index and read by index
`timescale 1ns/100ps
`default_nettype none
module tpf_mem (
  input wire logic ref_clk,
  input wire logic wr_en,
  input wire logic [tpf_pkg::AW-1:0] wr_idx,
  input wire tpf_pkg::tpf_word_t wr_data,
  input wire logic [tpf_pkg::AW-1:0] rd_idx,
  output tpf_pkg::tpf_word_t rd_data
);
  tpf_pkg::tpf_mem_t st_q;
  tpf_pkg::tpf_mem_t st_d;

  // Data words need no reset; pointers decide what is valid
  always_comb begin
    st_d = st_q;
    if (wr_en) begin
      st_d.word[wr_idx] = wr_data;
    end
  end

  always_ff @(posedge ref_clk) begin
    st_q <= st_d;
  end

  // Read is a plain index so the output register can load in the same tick
  assign rd_data = st_q.word[rd_idx];
endmodule // tpf_mem
`default_nettype wire

//--- hw/tpf_ptr_sync.sv
// Two-stage pointer capture advanced by the far port's clock enable
`timescale 1ns/100ps
`default_nettype none
module tpf_ptr_sync (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic tick,
  input wire tpf_pkg::tpf_ptr_t ptr_in,
  output tpf_pkg::tpf_ptr_t stage1,
  output tpf_pkg::tpf_ptr_t stage2
);
  tpf_pkg::tpf_sync_t st_q;
  tpf_pkg::tpf_sync_t st_d;

  // Stages move only on the far port's edges, which sets flag latency
  always_comb begin
    st_d = st_q;
    if (tick) begin
      st_d.s1 = ptr_in;
      st_d.s2 = st_q.s1;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= '{s1: tpf_pkg::PTR_ZERO, s2: tpf_pkg::PTR_ZERO};
    end else begin
      st_q <= st_d;
    end
  end

  assign stage1 = st_q.s1;
  assign stage2 = st_q.s2;
endmodule // tpf_ptr_sync
`default_nettype wire

//--- hw/tpf_top.sv
// Data access side of the two-queue, three-port buffer with loopback
`timescale 1ns/100ps
`default_nettype none
module tpf_top (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic fall_through_mode,
  input wire logic port_a_clock,
  input wire logic port_a_select_n,
  input wire logic port_a_direction,
  input wire logic port_a_strobe,
  input wire logic port_a_mailbox_sel,
  input wire logic port_a_loopback_n,
  input wire logic [tpf_pkg::DW-1:0] port_a_data_in,
  output logic [tpf_pkg::DW-1:0] port_a_data_out,
  output logic port_a_data_oe_n,
  input wire logic port_b_clock,
  input wire logic port_b_select_n,
  input wire logic port_b_read_strobe,
  input wire logic port_b_mailbox_sel,
  output logic [tpf_pkg::HW-1:0] port_b_data_out,
  output logic port_b_data_oe_n,
  input wire logic port_c_clock,
  input wire logic port_c_write_strobe,
  input wire logic port_c_mailbox_sel,
  input wire logic [tpf_pkg::HW-1:0] port_c_data_in,
  input wire logic [tpf_pkg::PW-1:0] q1_low_water_offset,
  input wire logic [tpf_pkg::PW-1:0] q1_high_water_offset,
  output logic q1_space_flag,
  output logic q1_data_flag_b,
  output logic q2_space_flag,
  output logic q2_data_flag_a,
  output logic q1_almost_empty_flag,
  output logic q1_almost_full_flag
);
  tpf_pkg::tpf_state_t st_q;
  tpf_pkg::tpf_state_t st_d;

  // Per-queue request and timing terms, index Q1 or Q2
  logic [1:0] wr_tick;
  logic [1:0] rd_tick;
  logic [1:0] wr_req;
  logic [1:0] rd_req;
  logic [1:0] wr_do;
  logic [1:0] rd_do;
  logic [1:0] fall_through_mode_load;
  logic [1:0] std_read;
  logic [1:0][tpf_pkg::DW-1:0] wdata;
  logic [1:0][tpf_pkg::DW-1:0] rdata;
  logic [1:0][tpf_pkg::PW-1:0] wptr_n;
  logic [1:0][tpf_pkg::PW-1:0] rptr_n;
  logic [1:0][tpf_pkg::PW-1:0] used;
  logic [1:0][tpf_pkg::PW-1:0] avail;
  logic [1:0][tpf_pkg::PW-1:0] wsync1;
  logic [1:0][tpf_pkg::PW-1:0] wsync2;
  logic [1:0][tpf_pkg::PW-1:0] rsync1;

  // Port decode terms
  logic a_qual;
  logic loop_on;
  logic b_qual;
  logic c_qual;
  logic [tpf_pkg::PW-1:0] high_mark;

  // Strobe gates every port request, only fall-through loads run without it, so selects may toggle freely while it is low
  assign a_qual = port_a_strobe & ~port_a_select_n & ~port_a_mailbox_sel;
  assign b_qual = port_b_read_strobe & ~port_b_select_n & ~port_b_mailbox_sel;
  assign c_qual = port_c_write_strobe & ~port_c_mailbox_sel;
  assign loop_on = ~port_a_loopback_n;

  // Each queue has its own port edges; cross-queue gating of access only in loopback
  assign wr_tick[tpf_pkg::Q1] = port_a_clock;
  assign rd_tick[tpf_pkg::Q1] = port_b_clock;
  assign wr_tick[tpf_pkg::Q2] = port_c_clock;
  assign rd_tick[tpf_pkg::Q2] = port_a_clock;

  // Queue one write: port A data normally, queue two output in loopback
  always_comb begin
    if (loop_on) begin
      wr_req[tpf_pkg::Q1] = a_qual & st_q.q[tpf_pkg::Q2].data_flag;
      wdata[tpf_pkg::Q1] = fall_through_mode ? st_q.q[tpf_pkg::Q2].out : rdata[tpf_pkg::Q2];
    end else begin
      wr_req[tpf_pkg::Q1] = a_qual & port_a_direction;
      wdata[tpf_pkg::Q1] = port_a_data_in;
    end
  end

  // Queue two read from port A; in loop with A writing, stop once queue one fills
  always_comb begin
    if (loop_on) begin
      rd_req[tpf_pkg::Q2] = a_qual & (~port_a_direction | st_q.q[tpf_pkg::Q1].space_flag);
    end else begin
      rd_req[tpf_pkg::Q2] = a_qual & ~port_a_direction;
    end
  end

  // Port B reads queue one, port C fills queue two with the half word
  assign rd_req[tpf_pkg::Q1] = b_qual;
  assign wr_req[tpf_pkg::Q2] = c_qual;
  assign wdata[tpf_pkg::Q2] = {tpf_pkg::HALF_PAD, port_c_data_in};

  // Queue pointer, storage and crossing logic, identical for both queues
  genvar gq;
  generate
    for (gq = 0; gq < 2; gq++) begin : g_queue
      // Writes only land while the space flag is up
      assign wr_do[gq] = wr_tick[gq] & wr_req[gq] & st_q.q[gq].space_flag;
      // Free-running pointers carry a wrap bit, so the index wraps on its own
      assign wptr_n[gq] = st_q.q[gq].wptr + {{(tpf_pkg::PW-1){1'b0}}, wr_do[gq]};
      assign used[gq] = wptr_n[gq] - rsync1[gq];

      // Fall-through loads when the memory holds a word and the register is free or read
      assign fall_through_mode_load[gq] = rd_tick[gq] & (wsync2[gq] != st_q.q[gq].rptr)
                             & (~st_q.q[gq].data_flag | rd_req[gq]);
      // Standard mode loads only on a qualified read with the flag up
      assign std_read[gq] = rd_tick[gq] & rd_req[gq] & st_q.q[gq].data_flag;
      assign rd_do[gq] = fall_through_mode ? fall_through_mode_load[gq] : std_read[gq];
      // Location freed as soon as the word reaches the output register
      assign rptr_n[gq] = st_q.q[gq].rptr + {{(tpf_pkg::PW-1){1'b0}}, rd_do[gq]};
      // Stored count excludes the output register word
      assign avail[gq] = (fall_through_mode ? wsync2[gq] : wsync1[gq]) - rptr_n[gq];

      tpf_mem u_mem (
        .ref_clk(ref_clk),
        .wr_en(wr_do[gq]),
        .wr_idx(st_q.q[gq].wptr[tpf_pkg::AW-1:0]),
        .wr_data(wdata[gq]),
        .rd_idx(st_q.q[gq].rptr[tpf_pkg::AW-1:0]),
        .rd_data(rdata[gq])
      );

      // Write pointer seen by the reading port, advanced on read edges
      tpf_ptr_sync u_wsync (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .tick(rd_tick[gq]),
        .ptr_in(st_q.q[gq].wptr),
        .stage1(wsync1[gq]),
        .stage2(wsync2[gq])
      );

      // Read pointer seen by the writing port, advanced on write edges
      tpf_ptr_sync u_rsync (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .tick(wr_tick[gq]),
        .ptr_in(st_q.q[gq].rptr),
        .stage1(rsync1[gq]),
        .stage2()
      );
    end
  endgenerate

  // Almost-full threshold: depth less the high water offset
  assign high_mark = tpf_pkg::DEPTH_CNT - q1_high_water_offset;

  // Next state for both queues, the almost flags and the pin drivers
  always_comb begin
    st_d = st_q;
    for (int q = 0; q < 2; q++) begin
      // Write side: full flag sees reads only after the capture stage
      if (wr_tick[q]) begin
        st_d.q[q].wptr = wptr_n[q];
        st_d.q[q].space_flag = (used[q] != tpf_pkg::DEPTH_CNT);
      end
      // Read side: output register moves only when a word is taken
      if (rd_do[q]) begin
        st_d.q[q].out = rdata[q];
        st_d.q[q].rptr = rptr_n[q];
      end
      if (rd_tick[q]) begin
        if (fall_through_mode) begin
          // Flag means a fresh word sits in the output register
          st_d.q[q].data_flag = fall_through_mode_load[q] | (st_q.q[q].data_flag & ~rd_req[q]);
        end else begin
          // Flag means the memory holds a word; nothing auto-loads
          st_d.q[q].data_flag = (avail[q] != tpf_pkg::WORDS_NONE);
        end
      end
    end

    // Almost-empty low from zero through the low water offset, port B edges
    if (rd_tick[tpf_pkg::Q1]) begin
      st_d.almost_empty = (avail[tpf_pkg::Q1] > q1_low_water_offset);
    end
    // Almost-full low from depth less offset upward, port A edges
    if (wr_tick[tpf_pkg::Q1]) begin
      st_d.almost_full = (used[tpf_pkg::Q1] < high_mark);
    end

    // Pin drive is pure select and port A direction decode, independent of strobes and loop
    st_d.a_oe_n = port_a_select_n | port_a_direction;
    st_d.b_oe_n = port_b_select_n;
  end

  // All state in one register; flags start low until the first port edge
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int q = 0; q < 2; q++) begin
        st_q.q[q].wptr <= tpf_pkg::PTR_ZERO;
        st_q.q[q].rptr <= tpf_pkg::PTR_ZERO;
        st_q.q[q].out <= tpf_pkg::WORD_RST;
        st_q.q[q].data_flag <= tpf_pkg::FLAG_RST;
        st_q.q[q].space_flag <= tpf_pkg::FLAG_RST;
      end
      st_q.almost_empty <= tpf_pkg::FLAG_RST;
      st_q.almost_full <= tpf_pkg::FLAG_RST;
      st_q.a_oe_n <= tpf_pkg::OE_N_RST;
      st_q.b_oe_n <= tpf_pkg::OE_N_RST;
    end else begin
      st_q <= st_d;
    end
  end

  // Outputs straight from the state register
  assign port_a_data_out = st_q.q[tpf_pkg::Q2].out;
  assign port_a_data_oe_n = st_q.a_oe_n;
  assign port_b_data_out = st_q.q[tpf_pkg::Q1].out[tpf_pkg::HW-1:0];
  assign port_b_data_oe_n = st_q.b_oe_n;
  assign q1_space_flag = st_q.q[tpf_pkg::Q1].space_flag;
  assign q1_data_flag_b = st_q.q[tpf_pkg::Q1].data_flag;
  assign q2_space_flag = st_q.q[tpf_pkg::Q2].space_flag;
  assign q2_data_flag_a = st_q.q[tpf_pkg::Q2].data_flag;
  assign q1_almost_empty_flag = st_q.almost_empty;
  assign q1_almost_full_flag = st_q.almost_full;
endmodule // tpf_top
`default_nettype wire

//--- tb/tpf_props.sv
// Port-level assertions for the triple port queue access block
`timescale 1ns/100ps
`default_nettype none
module tpf_props (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic port_a_clock,
  input wire logic port_a_select_n,
  input wire logic port_a_direction,
  input wire logic port_a_data_oe_n,
  input wire logic [tpf_pkg::DW-1:0] port_a_data_out,
  input wire logic port_b_clock,
  input wire logic port_b_select_n,
  input wire logic port_b_read_strobe,
  input wire logic port_b_mailbox_sel,
  input wire logic [tpf_pkg::HW-1:0] port_b_data_out,
  input wire logic port_b_data_oe_n,
  input wire logic port_c_clock,
  input wire logic fall_through_mode,
  input wire logic q1_space_flag,
  input wire logic q1_data_flag_b,
  input wire logic q2_space_flag
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  // Drivers follow the select decode one cycle late, never the strobes
  chk_a_oe_decode: assert property (
    $past(rst_b) |-> port_a_data_oe_n == $past(port_a_select_n | port_a_direction)) else $error("port A enable wrong");
  chk_b_oe_decode: assert property (
    $past(rst_b) |-> port_b_data_oe_n == $past(port_b_select_n)) else $error("port B enable wrong");
  // Flags and port A data move only on their own port's edge
  chk_q1_space_tick: assert property (
    !$stable(q1_space_flag) |-> $past(port_a_clock)) else $error("queue one space flag off its edge");
  chk_q1_data_tick: assert property (
    !$stable(q1_data_flag_b) |-> $past(port_b_clock)) else $error("queue one data flag off its edge");
  chk_q2_space_tick: assert property (
    !$stable(q2_space_flag) |-> $past(port_c_clock)) else $error("queue two space flag off its edge");
  chk_a_out_tick: assert property (
    !$stable(port_a_data_out) |-> $past(port_a_clock)) else $error("port A data moved off its edge");
  // An empty queue in standard mode or an unqualified read leaves the output register alone
  chk_b_empty_hold: assert property (
    port_b_clock && !q1_data_flag_b && !fall_through_mode |=> $stable(port_b_data_out))
    else $error("port B loaded while empty");
  chk_b_read_gate: assert property (
    port_b_clock && q1_data_flag_b && (port_b_mailbox_sel || !port_b_read_strobe || port_b_select_n)
    |=> $stable(port_b_data_out)) else $error("port B loaded without read");
  cov_b_read: cover property (port_b_clock && !port_b_select_n && port_b_read_strobe && q1_data_flag_b);
  cov_q1_ready: cover property ($rose(q1_data_flag_b));
  cov_q2_space: cover property ($rose(q2_space_flag));
endmodule // tpf_props
`default_nettype wire

//--- tb/tpf_port_partner.sv
// Far-side port clocks: each port edge is a one-cycle pulse at its own rate
`timescale 1ns/100ps
`default_nettype none
module tpf_port_partner #(parameter int DIV_A = 2, parameter int DIV_B = 3, parameter int DIV_C = 1) (
  input wire logic ref_clk,
  input wire logic rst_b,
  output logic tick_a,
  output logic tick_b,
  output logic tick_c
);
  int cnt;
  // Unequal divisors keep the three ports out of step with each other
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt <= 0;
      {tick_a, tick_b, tick_c} <= 3'h0;
    end else begin
      cnt <= cnt + 1;
      tick_a <= (cnt % DIV_A) == 0;
      tick_b <= (cnt % DIV_B) == 0;
      tick_c <= (cnt % DIV_C) == 0;
    end
  end
endmodule // tpf_port_partner
`default_nettype wire

//--- tb/tpf_top_tb.sv
// Self-checking bench: both queues written, refused, drained in both timing modes
`timescale 1ns/100ps
`default_nettype none
module tpf_top_tb;
  logic ref_clk = 1'b0, rst_b = 1'b0, fall_through_mode = 1'b0;
  logic port_a_clock, port_b_clock, port_c_clock;
  logic port_a_select_n = 1'b1, port_a_direction = 1'b0, port_a_strobe = 1'b0, port_a_mailbox_sel = 1'b0;
  logic port_a_loopback_n = 1'b1, port_a_data_oe_n, port_b_data_oe_n;
  logic port_b_select_n = 1'b1, port_b_read_strobe = 1'b0, port_b_mailbox_sel = 1'b0;
  logic port_c_write_strobe = 1'b0, port_c_mailbox_sel = 1'b0;
  logic q1_space_flag, q1_data_flag_b, q2_space_flag, q2_data_flag_a, q1_almost_empty_flag, q1_almost_full_flag;
  tpf_pkg::tpf_word_t port_a_data_in = 36'h000000000, port_a_data_out;
  logic [tpf_pkg::HW-1:0] port_b_data_out, port_c_data_in = 18'h00000;
  logic [tpf_pkg::PW-1:0] q1_low_water_offset = 12'h001, q1_high_water_offset = 12'h001;
  tpf_pkg::tpf_word_t q1_exp[$], q2_exp[$];
  logic [31:0] seed = 32'hCEAF30EC;
  int miscompares = 0, checks_done = 0;

  always #10 ref_clk = ~ref_clk;
  tpf_port_partner tpf_port_partner_i (.ref_clk, .rst_b, .tick_a(port_a_clock), .tick_b(port_b_clock),
    .tick_c(port_c_clock));
  tpf_top tpf_top_i (.*);

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Port 0 A write, 1 B read, 2 C write, 3 A read
  function automatic logic ready(input int p);
    case (p)
      0: return port_a_clock && q1_space_flag;
      1: return port_b_clock && q1_data_flag_b;
      2: return port_c_clock && q2_space_flag;
      default: return port_a_clock && q2_data_flag_a;
    endcase
  endfunction
  task automatic check(input string n, input tpf_pkg::tpf_word_t seen, input tpf_pkg::tpf_word_t exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // Holds the request until the sampling edge takes it; reads compare d
  task automatic xfer(input int p, input logic mb, input tpf_pkg::tpf_word_t d);
    int n;
    n = 0;
    port_a_select_n = !(p == 0 || p == 3);
    port_a_direction = (p == 0);
    port_a_mailbox_sel = mb;
    port_a_data_in = d;
    port_b_select_n = (p != 1);
    port_b_mailbox_sel = mb;
    port_c_mailbox_sel = mb;
    port_c_data_in = d[17:0];
    // Enables lag the selects by a clock; strobes low meanwhile so nothing is taken early
    @(negedge ref_clk);
    port_a_strobe = (p == 0 || p == 3);
    port_b_read_strobe = (p == 1);
    port_c_write_strobe = (p == 2);
    while (ready(p) !== 1'b1 && n < 400) begin
      @(negedge ref_clk);
      n++;
    end
    if (ready(p) !== 1'b1) begin
      miscompares++;
      finish_test();
    end
    if (p == 3) check("a_oe", {35'h0, port_a_data_oe_n}, 36'h000000000);
    if (p == 1) check("b_oe", {35'h0, port_b_data_oe_n}, 36'h000000000);
    if (fall_through_mode && p == 1) check("b_head", {18'h0, port_b_data_out}, d);
    if (fall_through_mode && p == 3) check("a_head", port_a_data_out, d);
    @(negedge ref_clk);
    if (!fall_through_mode && p == 1) check("b_data", {18'h0, port_b_data_out}, d);
    if (!fall_through_mode && p == 3) check("a_data", port_a_data_out, d);
    {port_a_strobe, port_b_read_strobe, port_c_write_strobe} = 3'h0;
    {port_a_select_n, port_b_select_n, port_a_mailbox_sel, port_b_mailbox_sel, port_c_mailbox_sel} = 5'h18;
    @(negedge ref_clk);
    check("oe_off", {34'h0, port_a_data_oe_n, port_b_data_oe_n}, 36'h000000003);
  endtask

  initial begin
    for (int m = 0; m < 2; m++) begin
      @(negedge ref_clk);
      rst_b = 1'b0;
      fall_through_mode = m[0];
      seed = lfsr(seed);
      q1_low_water_offset = {10'h0, seed[1:0] | 2'h1};
      q1_high_water_offset = {2'h0, seed[12:3]} + 12'h001;
      repeat (16) @(negedge ref_clk);
      check("rst_flags", {32'h0, q1_space_flag, q1_data_flag_b, q2_space_flag, q2_data_flag_a}, 36'h0);
      rst_b = 1'b1;
      // Mailbox-selected writes must reach neither queue
      xfer(0, 1'b1, 36'hFFFFFFFFF);
      xfer(2, 1'b1, 36'h00003FFFF);
      for (int i = 0; i < 6; i++) begin
        seed = lfsr(seed);
        q1_exp.push_back((i == 0) ? 36'hFFFFFFFFF : {seed, seed[7:4]});
        xfer(0, 1'b0, q1_exp[i]);
        q2_exp.push_back({18'h0, seed[29:12]});
        xfer(2, 1'b0, q2_exp[i]);
      end
      // Mailbox-selected read leaves the output register as it was
      xfer(1, 1'b1, m ? {18'h0, q1_exp[0][17:0]} : 36'h000000000);
      xfer(3, 1'b1, m ? q2_exp[0] : 36'h000000000);
      check("almost", {34'h0, q1_almost_empty_flag, q1_almost_full_flag}, 36'h000000003);
      // Queue two drains on port A; every other word also loops into queue one
      while (q2_exp.size() > 0) begin
        port_a_loopback_n = (q2_exp.size() % 2) != 0;
        if (!port_a_loopback_n) q1_exp.push_back(q2_exp[0]);
        xfer(3, 1'b0, q2_exp[0]);
        void'(q2_exp.pop_front());
      end
      port_a_loopback_n = 1'b1;
      // Queue one holds the port A words followed by the looped words
      while (q1_exp.size() > 0) begin
        xfer(1, 1'b0, {18'h0, q1_exp[0][17:0]});
        void'(q1_exp.pop_front());
      end
      check("drained", {34'h0, q1_data_flag_b, q1_almost_empty_flag}, 36'h000000000);
    end
    finish_test();
  end
endmodule // tpf_top_tb

bind tpf_top tpf_props tpf_props_i (.ref_clk, .rst_b, .port_a_clock, .port_a_select_n, .port_a_direction,
  .port_a_data_oe_n, .port_a_data_out, .port_b_clock, .port_b_select_n, .port_b_read_strobe, .port_b_mailbox_sel,
  .port_b_data_out, .port_b_data_oe_n, .port_c_clock, .fall_through_mode, .q1_space_flag, .q1_data_flag_b,
  .q2_space_flag);
`default_nettype wire
